// ===== hw/ffc_cfg_latch.sv
// catches the configuration pins at reset release and decodes them
`timescale 1ns/100ps
`default_nettype none
module ffc_cfg_latch
   import ffc_pkg::*;
(
   input  wire logic     core_clk,
   input  wire logic     reset,
   input  wire logic     firstLoadSel,
   input  wire logic     readExpandIn,
   input  wire logic     writeExpandIn,
   output var  logic     cfgTaken,
   output var  logic     fallThroughMode,
   output var  logic     syncPartial,
   output var  ffc_buf_t emptyDepth,
   output var  ffc_buf_t fullDepth
);
   // synchroniser runs through reset so its output is settled at release
   logic [2:0] pinMeta;
   logic [2:0] pinSync;
   logic       next_cfgTaken;
   logic       next_fallThroughMode;
   logic       next_syncPartial;
   ffc_buf_t   next_emptyDepth;
   ffc_buf_t   next_fullDepth;

   always_ff @(posedge core_clk) begin
      pinMeta <= {firstLoadSel, readExpandIn, writeExpandIn};
      pinSync <= pinMeta;
   end

   always_comb begin
      next_cfgTaken        = 1'b1;
      next_fallThroughMode = fallThroughMode;
      next_syncPartial     = syncPartial;
      next_emptyDepth      = emptyDepth;
      next_fullDepth       = fullDepth;
      if (!cfgTaken) begin
         // sync when the first-load pin is set, unless both expand bits set
         next_syncPartial = pinSync[2] & ~(pinSync[1] & pinSync[0]);
         case (pinSync[1:0])
            2'h1: begin
               next_fallThroughMode = 1'b1;
               next_emptyDepth      = FFC_BUF3;
               next_fullDepth       = FFC_BUF2;
            end
            2'h2: begin
               next_fallThroughMode = 1'b0;
               next_emptyDepth      = FFC_BUF2;
               next_fullDepth       = FFC_BUF2;
            end
            default: begin
               next_fallThroughMode = 1'b0;
               next_emptyDepth      = FFC_BUF1;
               next_fullDepth       = FFC_BUF1;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cfgTaken        <= 1'b0;
         fallThroughMode <= 1'b0;
         syncPartial     <= 1'b0;
         emptyDepth      <= FFC_BUF1;
         fullDepth       <= FFC_BUF1;
      end else begin
         cfgTaken        <= next_cfgTaken;
         fallThroughMode <= next_fallThroughMode;
         syncPartial     <= next_syncPartial;
         emptyDepth      <= next_emptyDepth;
         fullDepth       <= next_fullDepth;
      end
   end

   a_cfg_hold: assert property (@(posedge core_clk) disable iff (reset)
      $past(cfgTaken) |-> $stable(fallThroughMode) && $stable(syncPartial)
         && $stable(emptyDepth) && $stable(fullDepth))
      else $error("configuration changed after capture");
   a_sync_code: assert property (@(posedge core_clk) disable iff (reset)
      !cfgTaken ##1 cfgTaken |-> syncPartial ==
         ($past(pinSync[2]) && !($past(pinSync[1]) && $past(pinSync[0]))))
      else $error("partial flag timing decoded wrong");
   a_mode_code: assert property (@(posedge core_clk) disable iff (reset)
      !cfgTaken ##1 cfgTaken |-> fallThroughMode == ($past(pinSync[1:0]) == 2'h1))
      else $error("timing mode decoded wrong");
   a_depth_legal: assert property (@(posedge core_clk) disable iff (reset)
      (fallThroughMode && emptyDepth == FFC_BUF3 && fullDepth == FFC_BUF2)
      || (!fallThroughMode && emptyDepth == fullDepth && emptyDepth != FFC_BUF3))
      else $error("unsupported buffering mix");
endmodule
`default_nettype wire

// ===== hw/ffc_consts.svh
// constants for the fifo flag and configuration block
`ifndef FFC_CONSTS_SVH
`define FFC_CONSTS_SVH

`define FFC_DEPTH        9'h100
`define FFC_HALF         9'h080
`define FFC_OFS_W        12
`define FFC_OFS_RESET    12'h01F
`define FFC_MASK_RESET   4'h0

`define FFC_ADDR_EMPTY_OFS 8'h00
`define FFC_ADDR_FULL_OFS  8'h04
`define FFC_ADDR_STATE     8'h08
`define FFC_ADDR_INT_STAT  8'h0C
`define FFC_ADDR_INT_MASK  8'h10

`define FFC_EV_EMPTY     0
`define FFC_EV_FULL      1
`define FFC_EV_WR_REFUSE 2
`define FFC_EV_RD_REFUSE 3

`define FFC_RESP_OKAY    2'h0
`define FFC_RESP_SLVERR  2'h2

`endif

// ===== hw/ffc_flag_pipe.sv
// selectable one to three stage register buffer for a boundary flag
`timescale 1ns/100ps
`default_nettype none
module ffc_flag_pipe
   import ffc_pkg::*;
#(
   parameter logic RESET_VAL = 1'b0
) (
   input  wire logic     core_clk,
   input  wire logic     reset,
   input  var  ffc_buf_t depth,
   input  wire logic     rawFlag,
   output var  logic     flagOut
);
   logic [2:0] stage;
   logic [2:0] next_stage;
   logic [2:0] headSel;

   // the raw flag enters at the stage that leaves exactly depth flops to the output
   assign headSel = (depth == FFC_BUF3) ? 3'h1 : ((depth == FFC_BUF2) ? 3'h2 : 3'h4);

   genvar k;
   generate
      for (k = 0; k < 3; k++) begin : g_stage
         if (k == 0) begin : g_first
            assign next_stage[k] = rawFlag;
         end else begin : g_rest
            assign next_stage[k] = headSel[k] ? rawFlag : stage[k-1];
         end
      end
   endgenerate

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         stage <= {3{RESET_VAL}};
      end else begin
         stage <= next_stage;
      end
   end

   assign flagOut = stage[2];
endmodule
`default_nettype wire

// ===== hw/ffc_pkg.sv
// types shared by the fifo flag and configuration block
package ffc_pkg;
   typedef enum logic [2:0] {
      FFC_BUF1 = 3'h1,
      FFC_BUF2 = 3'h2,
      FFC_BUF3 = 3'h4
   } ffc_buf_t;
   typedef enum logic [5:0] {
      FFC_REG_EMPTY_OFS = 6'h01,
      FFC_REG_FULL_OFS  = 6'h02,
      FFC_REG_STATE     = 6'h04,
      FFC_REG_INT_STAT  = 6'h08,
      FFC_REG_INT_MASK  = 6'h10,
      FFC_REG_NONE      = 6'h20
   } ffc_reg_t;
   typedef logic [8:0] ffc_count_t;
endpackage

// ===== hw/ffc_top.sv
// fifo word count, status flags and axi4-lite register slave
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ffc_consts.svh"
module ffc_top
   import ffc_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        wrStrobe,
   input  wire logic        rdStrobe,
   input  wire logic        firstLoadSel,
   input  wire logic        readExpandIn,
   input  wire logic        writeExpandIn,
   output var  logic        emptyFlagN,
   output var  logic        fullFlagN,
   output var  logic        halfFullN,
   output var  logic        almostEmptyN,
   output var  logic        almostFullN,
   output var  logic        irq
);
   function automatic ffc_reg_t decodeAddr(input logic [7:0] addr);
      case (addr)
         `FFC_ADDR_EMPTY_OFS: decodeAddr = FFC_REG_EMPTY_OFS;
         `FFC_ADDR_FULL_OFS:  decodeAddr = FFC_REG_FULL_OFS;
         `FFC_ADDR_STATE:     decodeAddr = FFC_REG_STATE;
         `FFC_ADDR_INT_STAT:  decodeAddr = FFC_REG_INT_STAT;
         `FFC_ADDR_INT_MASK:  decodeAddr = FFC_REG_INT_MASK;
         default:             decodeAddr = FFC_REG_NONE;
      endcase
   endfunction

   logic                 cfgTaken;
   logic                 fallThroughMode;
   logic                 syncPartial;
   ffc_buf_t             emptyDepth;
   ffc_buf_t             fullDepth;

   ffc_cfg_latch u_cfg (
      .core_clk        (core_clk),
      .reset           (reset),
      .firstLoadSel    (firstLoadSel),
      .readExpandIn    (readExpandIn),
      .writeExpandIn   (writeExpandIn),
      .cfgTaken        (cfgTaken),
      .fallThroughMode (fallThroughMode),
      .syncPartial     (syncPartial),
      .emptyDepth      (emptyDepth),
      .fullDepth       (fullDepth)
   );

   // ---- word count and partial flags
   ffc_count_t           count;
   ffc_count_t           next_count;
   ffc_count_t           capacity;
   logic [`FFC_OFS_W-1:0] emptyOfs;
   logic [`FFC_OFS_W-1:0] fullOfs;
   logic                 wrTake;
   logic                 rdTake;
   logic                 next_halfFullN;
   logic                 next_almostEmptyN;
   logic                 next_almostFullN;
   ffc_count_t           flagSrc;
   logic [3:0]           events;

   // thresholds widened to 13 bits so large offsets never wrap
   function automatic logic aeHigh(input ffc_count_t c, input logic [11:0] n,
                                   input logic ft);
      aeHigh = {4'h0, c} > ({1'b0, n} + {12'h000, ft});
   endfunction
   function automatic logic afHigh(input ffc_count_t c, input logic [11:0] m,
                                   input ffc_count_t cap);
      afHigh = ({4'h0, c} + {1'b0, m}) < {4'h0, cap};
   endfunction

   always_comb begin
      capacity   = fallThroughMode ? (`FFC_DEPTH + 9'h001) : `FFC_DEPTH;
      // write refused when full, read refused when empty
      wrTake     = wrStrobe && (count != capacity);
      rdTake     = rdStrobe && (count != 9'h000);
      next_count = count + {8'h00, wrTake} - {8'h00, rdTake};
      // asynchronous timing follows the edge that moved the count
      flagSrc    = next_count;
      if (syncPartial) begin
         // synchronous timing re-evaluates on the flag's own side edge
         flagSrc = count;
      end
      // partial levels from the word count
      next_almostEmptyN = aeHigh(flagSrc, emptyOfs, fallThroughMode);
      next_almostFullN  = afHigh(flagSrc, fullOfs, capacity);
      next_halfFullN    = fallThroughMode ? (flagSrc < (`FFC_HALF + 9'h002))
                                          : (flagSrc <= `FFC_HALF);
      events = 4'h0;
      events[`FFC_EV_EMPTY]     = (count != 9'h000) && (next_count == 9'h000);
      events[`FFC_EV_FULL]      = (count != capacity) && (next_count == capacity);
      events[`FFC_EV_WR_REFUSE] = wrStrobe && !wrTake;
      events[`FFC_EV_RD_REFUSE] = rdStrobe && !rdTake;
   end

   // reset levels of the partial flags
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         count        <= 9'h000;
         halfFullN    <= 1'b1;
         almostEmptyN <= 1'b0;
         almostFullN  <= 1'b1;
      end else begin
         count        <= next_count;
         halfFullN    <= next_halfFullN;
         almostEmptyN <= next_almostEmptyN;
         almostFullN  <= next_almostFullN;
      end
   end

   // ---- boundary flags, the only ones that see the buffering depth
   logic rawEmptySide;
   logic rawFullSide;
   // output-ready is inverse sense of empty, input-ready of full
   assign rawEmptySide = fallThroughMode ? (next_count == 9'h000) : (next_count != 9'h000);
   assign rawFullSide  = fallThroughMode ? (next_count == capacity) : (next_count != capacity);

   // buffering only here; reset levels of the boundary flags
   ffc_flag_pipe #(.RESET_VAL(1'b0)) u_empty_pipe (
      .core_clk (core_clk),
      .reset    (reset),
      .depth    (emptyDepth),
      .rawFlag  (rawEmptySide),
      .flagOut  (emptyFlagN)
   );
   ffc_flag_pipe #(.RESET_VAL(1'b1)) u_full_pipe (
      .core_clk (core_clk),
      .reset    (reset),
      .depth    (fullDepth),
      .rawFlag  (rawFullSide),
      .flagOut  (fullFlagN)
   );

   // ---- axi4-lite slave, one write and one read in flight
   logic       awHeld, wHeld;
   logic [7:0] awAddrHeld;
   logic [31:0] wDataHeld;
   logic [3:0] wStrbHeld;
   logic [3:0] intStatus, intMask;
   logic       next_awHeld, next_wHeld, next_awready, next_wready, next_bvalid;
   logic       next_arready, next_rvalid, next_irq;
   logic [7:0] next_awAddrHeld;
   logic [31:0] next_wDataHeld, next_rdata;
   logic [3:0] next_wStrbHeld, next_intStatus, next_intMask;
   logic [1:0] next_bresp, next_rresp;
   logic [`FFC_OFS_W-1:0] next_emptyOfs, next_fullOfs;
   ffc_reg_t   wrReg, rdReg;

   always_comb begin
      next_awHeld     = awHeld;
      next_wHeld      = wHeld;
      next_awAddrHeld = awAddrHeld;
      next_wDataHeld  = wDataHeld;
      next_wStrbHeld  = wStrbHeld;
      next_bvalid     = s_axi_bvalid;
      next_bresp      = s_axi_bresp;
      next_rvalid     = s_axi_rvalid;
      next_rdata      = s_axi_rdata;
      next_rresp      = s_axi_rresp;
      next_emptyOfs   = emptyOfs;
      next_fullOfs    = fullOfs;
      next_intMask    = intMask;
      next_intStatus  = intStatus;
      wrReg           = decodeAddr(awAddrHeld);
      rdReg           = decodeAddr(s_axi_araddr);
      if (s_axi_awvalid && s_axi_awready) begin
         next_awHeld     = 1'b1;
         next_awAddrHeld = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_wHeld     = 1'b1;
         next_wDataHeld = s_axi_wdata;
         next_wStrbHeld = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (awHeld && wHeld && !s_axi_bvalid) begin
         next_awHeld = 1'b0;
         next_wHeld  = 1'b0;
         next_bvalid = 1'b1;
         next_bresp  = `FFC_RESP_OKAY;
         case (wrReg)
            FFC_REG_EMPTY_OFS: begin
               if (wStrbHeld[0]) next_emptyOfs[7:0]  = wDataHeld[7:0];
               if (wStrbHeld[1]) next_emptyOfs[11:8] = wDataHeld[11:8];
            end
            FFC_REG_FULL_OFS: begin
               if (wStrbHeld[0]) next_fullOfs[7:0]  = wDataHeld[7:0];
               if (wStrbHeld[1]) next_fullOfs[11:8] = wDataHeld[11:8];
            end
            FFC_REG_INT_MASK: begin
               if (wStrbHeld[0]) next_intMask = wDataHeld[3:0];
            end
            FFC_REG_STATE, FFC_REG_INT_STAT: begin
            end
            default: begin
               next_bresp = `FFC_RESP_SLVERR;
            end
         endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = `FFC_RESP_OKAY;
         next_rdata  = 32'h0000_0000;
         case (rdReg)
            FFC_REG_EMPTY_OFS: next_rdata[11:0] = emptyOfs;
            FFC_REG_FULL_OFS:  next_rdata[11:0] = fullOfs;
            FFC_REG_STATE:     next_rdata = {12'h000, emptyDepth, fullDepth, 2'h0,
                                             cfgTaken, syncPartial, fallThroughMode,
                                             count};
            FFC_REG_INT_STAT: begin
               next_rdata[3:0] = intStatus;
               next_intStatus  = 4'h0;
            end
            FFC_REG_INT_MASK:  next_rdata[3:0] = intMask;
            default:           next_rresp = `FFC_RESP_SLVERR;
         endcase
      end
      // a new event wins over a read clear in the same cycle
      next_intStatus = next_intStatus | events;
      next_irq       = |(next_intStatus & next_intMask);
      next_awready   = !next_awHeld && !next_bvalid;
      next_wready    = !next_wHeld && !next_bvalid;
      next_arready   = !next_rvalid;
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         awHeld        <= 1'b0;
         wHeld         <= 1'b0;
         awAddrHeld    <= 8'h00;
         wDataHeld     <= 32'h0000_0000;
         wStrbHeld     <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'h0;
         emptyOfs      <= `FFC_OFS_RESET;
         fullOfs       <= `FFC_OFS_RESET;
         intMask       <= `FFC_MASK_RESET;
         intStatus     <= 4'h0;
         irq           <= 1'b0;
      end else begin
         awHeld        <= next_awHeld;
         wHeld         <= next_wHeld;
         awAddrHeld    <= next_awAddrHeld;
         wDataHeld     <= next_wDataHeld;
         wStrbHeld     <= next_wStrbHeld;
         s_axi_awready <= next_awready;
         s_axi_wready  <= next_wready;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid  <= next_rvalid;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
         emptyOfs      <= next_emptyOfs;
         fullOfs       <= next_fullOfs;
         intMask       <= next_intMask;
         intStatus     <= next_intStatus;
         irq           <= next_irq;
      end
   end

   // ---- checks
   a_buf_delay: assert property (@(posedge core_clk) disable iff (reset)
      $past(cfgTaken, 4) |->
         (emptyDepth == FFC_BUF1 && emptyFlagN == $past(rawEmptySide, 1))
      || (emptyDepth == FFC_BUF2 && emptyFlagN == $past(rawEmptySide, 2))
      || (emptyDepth == FFC_BUF3 && emptyFlagN == $past(rawEmptySide, 3)))
      else $error("empty-side flag delay does not match depth");
   a_partial_unbuf: assert property (@(posedge core_clk) disable iff (reset)
      $past(cfgTaken) && !syncPartial |->
         halfFullN == (fallThroughMode ? (count < `FFC_HALF + 9'h002) : (count <= `FFC_HALF)))
      else $error("half-full delayed beyond its count");
   a_async_ae: assert property (@(posedge core_clk) disable iff (reset)
      $past(cfgTaken) && !syncPartial |->
         almostEmptyN == aeHigh(count, $past(emptyOfs), fallThroughMode))
      else $error("async almost-empty not on the moving edge");
   a_async_af: assert property (@(posedge core_clk) disable iff (reset)
      $past(cfgTaken) && !syncPartial |->
         almostFullN == afHigh(count, $past(fullOfs), capacity))
      else $error("async almost-full not on the moving edge");
   a_sync_ae: assert property (@(posedge core_clk) disable iff (reset)
      $past(cfgTaken) && syncPartial |->
         almostEmptyN == aeHigh($past(count), $past(emptyOfs), fallThroughMode))
      else $error("sync almost-empty timing wrong");
   a_sync_af: assert property (@(posedge core_clk) disable iff (reset)
      $past(cfgTaken) && syncPartial |->
         almostFullN == afHigh($past(count), $past(fullOfs), capacity))
      else $error("sync almost-full timing wrong");
   a_std_bound: assert property (@(posedge core_clk) disable iff (reset)
      !fallThroughMode && count == `FFC_DEPTH && wrStrobe && !rdStrobe |=> count == `FFC_DEPTH)
      else $error("standard mode passed its depth");
   a_ft_bound: assert property (@(posedge core_clk) disable iff (reset)
      fallThroughMode |-> count <= `FFC_DEPTH + 9'h001)
      else $error("fall-through count beyond capacity");
   a_ofs_reset: assert property (@(posedge core_clk)
      $fell(reset) |-> emptyOfs == `FFC_OFS_RESET && fullOfs == `FFC_OFS_RESET)
      else $error("offset defaults wrong");
   a_flag_reset: assert property (@(posedge core_clk)
      $fell(reset) |-> halfFullN && almostFullN && !almostEmptyN && fullFlagN && !emptyFlagN)
      else $error("reset flag levels wrong");
endmodule
`default_nettype wire

// ===== sim/ffc_stream_partner.sv
// writer and reader stand-in: configuration pins and one-clock strobes
`timescale 1ns/100ps
`default_nettype none
module ffc_stream_partner (
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic [2:0] cfgPick,
   input  wire logic       wantWr,
   input  wire logic       wantRd,
   output var  logic [2:0] cfgPins,
   output var  logic       wrStrobe,
   output var  logic       rdStrobe
);
   always @(posedge reset)
      cfgPins <= cfgPick;
   always_ff @(posedge core_clk) begin
      wrStrobe <= wantWr;
      rdStrobe <= wantRd;
   end
endmodule
`default_nettype wire

// ===== sim/tb_ffc_top.sv
// self-checking bench: flag thresholds, configuration and register access
`timescale 1ns/100ps
`default_nettype none
module tb_ffc_top;
   logic        core_clk = 1'b0, reset = 1'b0, wantWr = 1'b0, wantRd = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h36;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [2:0]  cfgPick = 3'h4, cfgPins;
   logic        wrStrobe, rdStrobe, emptyFlagN, fullFlagN, halfFullN, almostEmptyN;
   logic        almostFullN, irq;
   logic [31:0] expQ[$];
   int          mismatches = 0, n_compared = 0, cnt;
   ffc_top i_ffc_top (.*, .firstLoadSel(cfgPins[2]), .readExpandIn(cfgPins[1]),
                      .writeExpandIn(cfgPins[0]));
   ffc_stream_partner i_ffc_stream_partner (.*);
   always #12.5 core_clk = ~core_clk;
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] e, input logic [31:0] got);
      n_compared++;
      if (got !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, e, got);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge core_clk);
   endtask
   // a wait that ran out of its bound ends the run
   task automatic hang(input int t);
      if (t >= 50) begin
         mismatches++;
         complete_run();
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int t;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (t = 0; t < 50 && !(s_axi_bvalid && !s_axi_awvalid && !s_axi_wvalid); t++) begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      // let an edge pass so a following call never re-raises bready in this step
      tick(1);
      hang(t);
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] e);
      int t;
      expQ.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (t = 0; t < 50; t++) begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      tick(1);
      hang(t);
   endtask
   // every read in this bench targets a mapped register, so the response is always okay
   always @(posedge core_clk)
      if (s_axi_rvalid && s_axi_rready) begin
         check("rdata", expQ.pop_front(), s_axi_rdata);
         check("rresp", 32'h0000_0000, {30'h0, s_axi_rresp});
      end
   task automatic flags(input int c, input logic ft);
      int cap;
      cap = ft ? 257 : 256;
      check("flags", {27'h0, ft ? c == 0 : c != 0, ft ? c == cap : c != cap,
            c < (ft ? 130 : 129), c > 31 + int'(ft), c < cap - 31},
            {27'h0, emptyFlagN, fullFlagN, halfFullN, almostEmptyN, almostFullN});
   endtask
   // random gap lengths; the wait always outlasts the three-stage flag pipe
   task automatic step(input logic wr, input int c, input logic ft);
      wantWr <= wr;
      wantRd <= !wr;
      tick(1);
      wantWr <= 1'b0;
      wantRd <= 1'b0;
      seed = xs(seed);
      tick(5 + int'(seed[0]));
      flags(c, ft);
   endtask
   initial begin
      for (int k = 0; k < 2; k++) begin
         cfgPick = k ? 3'h1 : 3'h4;
         reset <= 1'b1;
         tick(16);
         flags(0, 1'b0);
         reset <= 1'b0;
         tick(8);
         flags(0, k[0]);
         axi_rd(8'h08, k ? 32'h0008_8A00 : 32'h0002_4C00);
         axi_wr(8'h10, 32'h0000_000F, 2'h0);
         axi_wr(8'h40, 32'h0000_0001, 2'h2);
         for (cnt = 1; cnt <= 258; cnt++) step(1'b1, cnt > 256 + k ? 256 + k : cnt, k[0]);
         check("irq", 32'h1, {31'h0, irq});
         axi_rd(8'h0C, 32'h0000_0006);
         tick(2);
         check("irq", 32'h0, {31'h0, irq});
         for (cnt = 255 + k; cnt >= -1; cnt--) step(1'b0, cnt < 0 ? 0 : cnt, k[0]);
         axi_rd(8'h0C, 32'h0000_0009);
         // second pass proves reset restored the empty offset the first pass overwrote
         axi_rd(8'h00, 32'h0000_001F);
         axi_rd(8'h04, 32'h0000_001F);
         seed = xs(seed);
         axi_wr(8'h00, seed, 2'h0);
         axi_rd(8'h00, {20'h0, seed[11:0]});
      end
      complete_run();
   end
endmodule
`default_nettype wire
